// ### core/tmr_map.svh
// register addresses, bit positions, reset values and clock ratios of the timer unit
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH

// special function register addresses
`define TMR_A_TIMER_CONTROL  8'h88
`define TMR_A_TIMER_MODE     8'h89
`define TMR_A_ZERO_LOW       8'h8A
`define TMR_A_ONE_LOW        8'h8B
`define TMR_A_ZERO_HIGH      8'h8C
`define TMR_A_ONE_HIGH       8'h8D
`define TMR_A_THIRD_CONTROL  8'hC8
`define TMR_A_THIRD_MODE     8'hC9
`define TMR_A_THIRD_RLD_LOW  8'hCA
`define TMR_A_THIRD_RLD_HIGH 8'hCB
`define TMR_A_THIRD_CNT_LOW  8'hCC
`define TMR_A_THIRD_CNT_HIGH 8'hCD

// timer control register bits
`define TMR_B_ONE_OVF        7
`define TMR_B_ONE_RUN        6
`define TMR_B_ZERO_OVF       5
`define TMR_B_ZERO_RUN       4

// timer mode register fields
`define TMR_B_ONE_GATE       7
`define TMR_B_ONE_SEL        6
`define TMR_F_ONE_MODE       5:4
`define TMR_B_ZERO_GATE      3
`define TMR_B_ZERO_SEL       2
`define TMR_F_ZERO_MODE      1:0

// third timer control and mode bits
`define TMR_B_T3_OVF         7
`define TMR_B_T3_EXT         6
`define TMR_B_T3_RXCLK       5
`define TMR_B_T3_TXCLK       4
`define TMR_B_T3_TRIG_EN     3
`define TMR_B_T3_RUN         2
`define TMR_B_T3_SEL         1
`define TMR_B_T3_CAP         0
`define TMR_B_T3_OE          1
`define TMR_B_T3_DOWN        0

// reset values and fixed patterns
`define TMR_RST_BYTE         8'h00
`define TMR_RST_WORD         16'h0000
`define TMR_ONES_BYTE        8'hFF
`define TMR_ONES_WORD        16'hFFFF

// oscillator clocks per machine cycle and per third-timer internal step
`define TMR_MCYC_CLKS        12
`define TMR_THIRD_DIV        6

`endif

// ### core/tmr_pkg.sv
// types shared by the timer unit
package tmr_pkg;

	// general timer mode field encoding
	typedef enum logic [1:0] {
		TMR_GM_PRESCALED = 2'b00,
		TMR_GM_CASCADED  = 2'b01,
		TMR_GM_RELOAD8   = 2'b10,
		TMR_GM_SPLIT     = 2'b11
	} tmr_gmode_type;

	// third timer operating mode
	typedef enum logic [2:0] {
		TMR_T3_OFF     = 3'b000,
		TMR_T3_RELOAD  = 3'b001,
		TMR_T3_CAPTURE = 3'b010,
		TMR_T3_CLKOUT  = 3'b011,
		TMR_T3_BAUD    = 3'b100
	} tmr_t3mode_type;

endpackage : tmr_pkg

// ### core/tmr_timer_unit.sv
// two general timers plus third timer control, flags and baud source selection
`timescale 1ns/1ps
`include "tmr_map.svh"

// Operation
// - prescaled mode counts thirteen bits: high byte plus low five bits of low byte.
// - rollover of the active counter from all ones sets that timer's overflow flag.
// - general timer counts while run bit is set and gate clear or interrupt pin high.
// - setting a run bit leaves the count registers untouched.
// - timer one gate is mode bit 7, timer zero gate is mode bit 3.
// - cascaded mode uses all sixteen bits of high and low byte.
// - eight-bit mode reloads low byte from high byte on overflow, sets flag.
// - timer one in mode 3 stops and holds, as if its run bit were clear.
// - timer zero mode 3: low byte uses zero controls, high byte uses one's run bit and flag only.
// - then timer one runs outside its mode 3, stops inside it, without flag.
// - third timer mode decoded from serial selects, capture bit and output enable.
// - third timer is off whenever its run bit is clear.
// - third overflow flag set on overflow, not in baud or clock-out, software clears.
// - external flag set by trigger falling edge when enabled in capture, baud, reload without down count enable.
// - receive clock select picks third timer or timer one overflows for receive.
// - transmit clock select picks third timer or timer one overflows for transmit.
// - enabled trigger edge captures, or reloads without down count enable, unless clocking the serial port.
// - third select bit: internal clock (over six except in baud and clock-out), or count pin falling edges.
// - capture bit picks capture or reload; serial clocking forces reload on overflow.
// - mode register holds output enable at bit 1, down count enable at bit 0.
// - mode field: 0 prescaled, 1 cascaded, 2 eight-bit reload, 3 split or stopped.
// - select bit clear counts internal clock, set counts the timer's count pin.
// - general overflow flag cleared on interrupt vector or by software.
module tmr_timer_unit
	import tmr_pkg::*;
#(
	parameter int unsigned MCYC_CLKS = `TMR_MCYC_CLKS,
	parameter int unsigned THIRD_DIV = `TMR_THIRD_DIV
)
(
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	input  wire logic       ce_i,
	input  wire logic [7:0] sfr_addr_i,
	input  wire logic       sfr_wr_i,
	input  wire logic [7:0] sfr_wdata_i,
	input  wire logic [1:0] count_pin_i,
	input  wire logic [1:0] external_irq_pin_i,
	input  wire logic [1:0] vector_ack_i,
	input  wire logic       third_count_pin_i,
	input  wire logic       third_trigger_pin_i,
	output logic      [7:0] sfr_rdata_o,
	output logic      [1:0] timer_overflow_flag_o,
	output logic            third_irq_o,
	output logic            rx_baud_tick_o,
	output logic            tx_baud_tick_o,
	output logic            clock_out_o,
	output logic            clock_out_en_o
);

	localparam int MW = (MCYC_CLKS > 1) ? $clog2(MCYC_CLKS) : 1;
	localparam int DW = (THIRD_DIV > 1) ? $clog2(THIRD_DIV) : 1;

	// one step of a general timer: {overflow, high, low}
	function automatic logic [16:0] tmr_step(input tmr_gmode_type m,
						 input logic [7:0] th,
						 input logic [7:0] tl);
		logic [5:0]  low5;
		logic [8:0]  hi;
		logic [16:0] wide;
		logic [8:0]  byte8;
		low5 = {1'b0, tl[4:0]} + 6'h01;
		hi = {1'b0, th} + {8'h00, low5[5]};
		wide = {1'b0, th, tl} + 17'h00001;
		byte8 = {1'b0, tl} + 9'h001;
		case (m)
			TMR_GM_PRESCALED: tmr_step = {hi[8], hi[7:0], tl[7:5], low5[4:0]};
			TMR_GM_CASCADED:  tmr_step = wide;
			TMR_GM_RELOAD8:   tmr_step = {byte8[8], th, byte8[8] ? th : byte8[7:0]};
			TMR_GM_SPLIT:     tmr_step = {byte8[8], th, byte8[7:0]};
			default:          tmr_step = wide;
		endcase
	endfunction : tmr_step

	// register state
	logic [7:0]    timer_control_register_q;
	logic [7:0]    timer_mode_register_q;
	logic [7:0]    tl_q [2];
	logic [7:0]    th_q [2];
	logic [7:0]    t3con_q;
	logic [1:0]    t3mod_q;
	logic [15:0]   t3cnt_q;
	logic [15:0]   t3rld_q;
	logic [7:0]    rdata_q;
	logic          irq3_q;
	logic          rx_tick_q;
	logic          tx_tick_q;
	logic          clkout_q;
	logic          clkout_en_q;

	// machine cycle and pin samples
	logic [MW-1:0] mcyc_q;
	logic [DW-1:0] div3_q;
	logic [1:0]    cpin_q;
	logic [1:0]    cpin_prev_q;
	logic [1:0]    irqpin_q;
	logic          t3pin_q;
	logic          t3pin_prev_q;
	logic          trig_q;
	logic          trig_prev_q;

	// machine cycle strobe and sampled pin edges
	wire           mcyc_tick = (mcyc_q == MW'(0));
	wire           div3_tick = (div3_q == DW'(0));
	wire [1:0]     cpin_fall = cpin_prev_q & ~cpin_q;
	wire           t3pin_fall = t3pin_prev_q & ~t3pin_q;
	wire           trig_fall = trig_prev_q & ~trig_q;

	// address decode
	wire           wr_timer_control_register = sfr_wr_i & (sfr_addr_i == `TMR_A_TIMER_CONTROL);
	wire           wr_timer_mode_register = sfr_wr_i & (sfr_addr_i == `TMR_A_TIMER_MODE);
	wire           wr_tl0 = sfr_wr_i & (sfr_addr_i == `TMR_A_ZERO_LOW);
	wire           wr_tl1 = sfr_wr_i & (sfr_addr_i == `TMR_A_ONE_LOW);
	wire           wr_th0 = sfr_wr_i & (sfr_addr_i == `TMR_A_ZERO_HIGH);
	wire           wr_th1 = sfr_wr_i & (sfr_addr_i == `TMR_A_ONE_HIGH);
	wire           wr_t3con = sfr_wr_i & (sfr_addr_i == `TMR_A_THIRD_CONTROL);
	wire           wr_t3mod = sfr_wr_i & (sfr_addr_i == `TMR_A_THIRD_MODE);
	wire           wr_rldl = sfr_wr_i & (sfr_addr_i == `TMR_A_THIRD_RLD_LOW);
	wire           wr_rldh = sfr_wr_i & (sfr_addr_i == `TMR_A_THIRD_RLD_HIGH);
	wire           wr_cntl = sfr_wr_i & (sfr_addr_i == `TMR_A_THIRD_CNT_LOW);
	wire           wr_cnth = sfr_wr_i & (sfr_addr_i == `TMR_A_THIRD_CNT_HIGH);

	// general timer controls
	wire           tmr_gmode_type gm0 = tmr_gmode_type'(timer_mode_register_q[`TMR_F_ZERO_MODE]);
	wire           tmr_gmode_type gm1 = tmr_gmode_type'(timer_mode_register_q[`TMR_F_ONE_MODE]);
	wire           gate0 = timer_mode_register_q[`TMR_B_ZERO_GATE];
	wire           gate1 = timer_mode_register_q[`TMR_B_ONE_GATE];
	wire           split0 = (gm0 == TMR_GM_SPLIT);

	// count source: machine cycle or a sampled falling edge on the count pin
	wire           src0 = timer_mode_register_q[`TMR_B_ZERO_SEL] ? (cpin_fall[0] & mcyc_tick) : mcyc_tick;
	wire           src1 = timer_mode_register_q[`TMR_B_ONE_SEL] ? (cpin_fall[1] & mcyc_tick) : mcyc_tick;

	// run qualification; the run bit only gates, it never touches the count
	wire           run0 = timer_control_register_q[`TMR_B_ZERO_RUN] & (~gate0 | irqpin_q[0]) & src0;
	wire           run1 = timer_control_register_q[`TMR_B_ONE_RUN] & (~gate1 | irqpin_q[1]) & src1 &
			      (gm1 != TMR_GM_SPLIT);
	wire           th0_run = split0 & timer_control_register_q[`TMR_B_ONE_RUN] & mcyc_tick;

	wire [16:0]    step0 = tmr_step(gm0, th_q[0], tl_q[0]);
	wire [16:0]    step1 = tmr_step(gm1, th_q[1], tl_q[1]);
	wire [8:0]     th0_inc = {1'b0, th_q[0]} + 9'h001;

	// overflow events
	wire           ovf0 = run0 & step0[16];
	wire           ovf1 = run1 & step1[16];
	wire           th0_ovf = th0_run & th0_inc[8];
	wire           tf1_set = split0 ? th0_ovf : ovf1;

	// third timer mode decode
	wire           rxclk = t3con_q[`TMR_B_T3_RXCLK];
	wire           txclk = t3con_q[`TMR_B_T3_TXCLK];
	wire           trig_en = t3con_q[`TMR_B_T3_TRIG_EN];
	wire           down_count_enable = t3mod_q[`TMR_B_T3_DOWN];
	tmr_t3mode_type t3mode;
	assign t3mode = ~t3con_q[`TMR_B_T3_RUN] ? TMR_T3_OFF :
			(rxclk | txclk) ? TMR_T3_BAUD :
			t3con_q[`TMR_B_T3_CAP] ? TMR_T3_CAPTURE :
			t3mod_q[`TMR_B_T3_OE] ? TMR_T3_CLKOUT : TMR_T3_RELOAD;

	// baud and clock-out step every oscillator clock, otherwise every sixth
	wire           fast3 = (t3mode == TMR_T3_BAUD) | (t3mode == TMR_T3_CLKOUT);
	wire           src3 = t3con_q[`TMR_B_T3_SEL] ? (t3pin_fall & mcyc_tick) :
			      (fast3 | div3_tick);
	wire           run3 = (t3mode != TMR_T3_OFF) & src3;
	wire           down3 = (t3mode == TMR_T3_RELOAD) & down_count_enable & ~trig_q;
	wire           up_ovf3 = run3 & ~down3 & (t3cnt_q == `TMR_ONES_WORD);
	wire           dn_udf3 = run3 & down3 & (t3cnt_q == t3rld_q);
	wire           roll3 = up_ovf3 | dn_udf3;
	wire           updown = (t3mode == TMR_T3_RELOAD) & down_count_enable;

	// trigger edge qualified; in up/down mode the pin steers direction instead
	wire           trig_evt = trig_fall & mcyc_tick & trig_en & ~updown &
			      ((t3mode == TMR_T3_RELOAD) | (t3mode == TMR_T3_CAPTURE) |
			       (t3mode == TMR_T3_BAUD));
	wire           trig_reload = trig_evt & (t3mode == TMR_T3_RELOAD);
	wire           trig_capture = trig_evt & (t3mode == TMR_T3_CAPTURE);
	wire           reload_on_ovf = up_ovf3 & (t3mode != TMR_T3_CAPTURE);
	wire           tf3_set = roll3 & ((t3mode == TMR_T3_RELOAD) |
			      (t3mode == TMR_T3_CAPTURE));
	wire           baud_ovf3 = up_ovf3 & (t3mode == TMR_T3_BAUD);
	wire [15:0]    cnt3_inc = t3cnt_q + 16'h0001;
	wire [15:0]    cnt3_dec = t3cnt_q - 16'h0001;

	// flag next values: a hardware set always wins over a clear
	logic [7:0]    timer_control_register_d;
	logic [7:0]    t3con_d;
	always_comb
	begin
		timer_control_register_d = wr_timer_control_register ? sfr_wdata_i : timer_control_register_q;
		timer_control_register_d[`TMR_B_ZERO_OVF] = ovf0 | (wr_timer_control_register ? sfr_wdata_i[`TMR_B_ZERO_OVF] :
				(timer_control_register_q[`TMR_B_ZERO_OVF] & ~vector_ack_i[0]));
		timer_control_register_d[`TMR_B_ONE_OVF] = tf1_set | (wr_timer_control_register ? sfr_wdata_i[`TMR_B_ONE_OVF] :
				(timer_control_register_q[`TMR_B_ONE_OVF] & ~vector_ack_i[1]));
		t3con_d = wr_t3con ? sfr_wdata_i : t3con_q;
		t3con_d[`TMR_B_T3_OVF] = tf3_set | t3con_d[`TMR_B_T3_OVF];
		t3con_d[`TMR_B_T3_EXT] = trig_evt |
				(t3con_d[`TMR_B_T3_EXT] ^ (updown & roll3));
	end

	// read data selection
	logic [7:0]    rd_mux;
	always_comb
	begin
		case (sfr_addr_i)
			`TMR_A_TIMER_CONTROL:  rd_mux = timer_control_register_q;
			`TMR_A_TIMER_MODE:     rd_mux = timer_mode_register_q;
			`TMR_A_ZERO_LOW:       rd_mux = tl_q[0];
			`TMR_A_ONE_LOW:        rd_mux = tl_q[1];
			`TMR_A_ZERO_HIGH:      rd_mux = th_q[0];
			`TMR_A_ONE_HIGH:       rd_mux = th_q[1];
			`TMR_A_THIRD_CONTROL:  rd_mux = t3con_q;
			`TMR_A_THIRD_MODE:     rd_mux = {6'h00, t3mod_q}; // reserved bits read zero
			`TMR_A_THIRD_RLD_LOW:  rd_mux = t3rld_q[7:0];
			`TMR_A_THIRD_RLD_HIGH: rd_mux = t3rld_q[15:8];
			`TMR_A_THIRD_CNT_LOW:  rd_mux = t3cnt_q[7:0];
			`TMR_A_THIRD_CNT_HIGH: rd_mux = t3cnt_q[15:8];
			default:               rd_mux = `TMR_RST_BYTE;
		endcase
	end

	// machine cycle divider and pin sampling once per machine cycle
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			mcyc_q <= '0;
			cpin_q <= 2'h0;
			cpin_prev_q <= 2'h0;
			irqpin_q <= 2'h0;
			t3pin_q <= 1'b0;
			t3pin_prev_q <= 1'b0;
			trig_q <= 1'b0;
			trig_prev_q <= 1'b0;
		end
		else if (ce_i)
		begin
			mcyc_q <= (mcyc_q == MW'(MCYC_CLKS - 1)) ? MW'(0) : mcyc_q + MW'(1);
			if (mcyc_tick)
			begin
				cpin_q <= count_pin_i;
				cpin_prev_q <= cpin_q;
				irqpin_q <= external_irq_pin_i;
				t3pin_q <= third_count_pin_i;
				t3pin_prev_q <= t3pin_q;
				trig_q <= third_trigger_pin_i;
				trig_prev_q <= trig_q;
			end
		end
	end

	// control registers and flags
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			timer_control_register_q <= `TMR_RST_BYTE;
			timer_mode_register_q <= `TMR_RST_BYTE;
			t3con_q <= `TMR_RST_BYTE;
			t3mod_q <= 2'h0;
		end
		else if (ce_i)
		begin
			timer_control_register_q <= timer_control_register_d;
			t3con_q <= t3con_d;
			if (wr_timer_mode_register)
				timer_mode_register_q <= sfr_wdata_i;
			if (wr_t3mod)
				t3mod_q <= sfr_wdata_i[1:0]; // upper bits are not stored
		end
	end

	// general timer count bytes; a software write beats a count step
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			tl_q[0] <= `TMR_RST_BYTE;
			tl_q[1] <= `TMR_RST_BYTE;
			th_q[0] <= `TMR_RST_BYTE;
			th_q[1] <= `TMR_RST_BYTE;
		end
		else if (ce_i)
		begin
			if (wr_tl0)
				tl_q[0] <= sfr_wdata_i;
			else if (run0)
				tl_q[0] <= step0[7:0];
			if (wr_th0)
				th_q[0] <= sfr_wdata_i;
			else if (th0_run)
				th_q[0] <= th0_inc[7:0];
			else if (run0)
				th_q[0] <= step0[15:8];
			if (wr_tl1)
				tl_q[1] <= sfr_wdata_i;
			else if (run1)
				tl_q[1] <= step1[7:0];
			if (wr_th1)
				th_q[1] <= sfr_wdata_i;
			else if (run1)
				th_q[1] <= step1[15:8];
		end
	end

	// third timer prescaler, counter and reload/capture word
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			div3_q <= '0;
			t3cnt_q <= `TMR_RST_WORD;
			t3rld_q <= `TMR_RST_WORD;
		end
		else if (ce_i)
		begin
			div3_q <= (div3_q == DW'(THIRD_DIV - 1)) ? DW'(0) : div3_q + DW'(1);
			if (wr_cntl)
				t3cnt_q[7:0] <= sfr_wdata_i;
			else if (wr_cnth)
				t3cnt_q[15:8] <= sfr_wdata_i;
			else if (trig_reload | reload_on_ovf)
				t3cnt_q <= t3rld_q;
			else if (dn_udf3)
				t3cnt_q <= `TMR_ONES_WORD;
			else if (run3)
				t3cnt_q <= down3 ? cnt3_dec : cnt3_inc;
			if (wr_rldl)
				t3rld_q[7:0] <= sfr_wdata_i;
			else if (wr_rldh)
				t3rld_q[15:8] <= sfr_wdata_i;
			else if (trig_capture)
				t3rld_q <= t3cnt_q;
		end
	end

	// registered outputs: interrupt, baud ticks and clock-out
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			rdata_q <= `TMR_RST_BYTE;
			irq3_q <= 1'b0;
			rx_tick_q <= 1'b0;
			tx_tick_q <= 1'b0;
			clkout_q <= 1'b0;
			clkout_en_q <= 1'b0;
		end
		else if (ce_i)
		begin
			rdata_q <= rd_mux;
			irq3_q <= t3con_d[`TMR_B_T3_OVF] | t3con_d[`TMR_B_T3_EXT];
			rx_tick_q <= rxclk ? baud_ovf3 : ovf1;
			tx_tick_q <= txclk ? baud_ovf3 : ovf1;
			clkout_en_q <= (t3mode == TMR_T3_CLKOUT);
			if (up_ovf3 & (t3mode == TMR_T3_CLKOUT))
				clkout_q <= ~clkout_q;               // half period per rollover
		end
	end

	assign sfr_rdata_o = rdata_q;
	assign timer_overflow_flag_o = {timer_control_register_q[`TMR_B_ONE_OVF], timer_control_register_q[`TMR_B_ZERO_OVF]};
	assign third_irq_o = irq3_q;
	assign rx_baud_tick_o = rx_tick_q;
	assign tx_baud_tick_o = tx_tick_q;
	assign clock_out_o = clkout_q;
	assign clock_out_en_o = clkout_en_q;

endmodule : tmr_timer_unit

// ### tb/tmr_timer_unit_chk.sv
// port assertions for the timer unit, bound to every instance
`timescale 1ns/1ps
`include "tmr_map.svh"
module tmr_timer_unit_chk
(
	input wire logic       clk_i,
	input wire logic       nrst_i,
	input wire logic       ce_i,
	input wire logic [7:0] sfr_addr_i,
	input wire logic       sfr_wr_i,
	input wire logic [7:0] sfr_wdata_i,
	input wire logic [1:0] vector_ack_i,
	input wire logic [7:0] sfr_rdata_o,
	input wire logic [1:0] timer_overflow_flag_o,
	input wire logic       rx_baud_tick_o,
	input wire logic       tx_baud_tick_o,
	input wire logic       clock_out_o,
	input wire logic       clock_out_en_o
);
	logic       run0_q;
	logic [7:0] t3c_q;
	logic [1:0] t3m_q;
	wire        ctl_wr = ce_i && sfr_wr_i && sfr_addr_i == `TMR_A_TIMER_CONTROL;
	wire        co_mode = t3c_q[2] && !t3c_q[5] && !t3c_q[4] && !t3c_q[0] && t3m_q[1];

	// shadow of software-written bits; hardware writes only third control bits 7 and 6, which no check reads
	always_ff @(posedge clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			run0_q <= 1'b0;
			t3c_q <= 8'h00;
			t3m_q <= 2'h0;
		end
		else if (ce_i && sfr_wr_i)
		begin
			if (sfr_addr_i == `TMR_A_TIMER_CONTROL) run0_q <= sfr_wdata_i[4];
			if (sfr_addr_i == `TMR_A_THIRD_CONTROL) t3c_q <= sfr_wdata_i;
			if (sfr_addr_i == `TMR_A_THIRD_MODE) t3m_q <= sfr_wdata_i[1:0];
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);

	timer_mode_register_readback_a: assert property (ce_i && sfr_wr_i && sfr_addr_i == 8'h89 ##1
		ce_i && !sfr_wr_i && sfr_addr_i == 8'h89 |=> sfr_rdata_o == $past(sfr_wdata_i, 2))
		else $error("timer mode register read back differs");
	t3mod_rsv_a: assert property (ce_i && sfr_addr_i == 8'hC9 |=> sfr_rdata_o[7:2] == 6'h00)
		else $error("third mode reserved bits not zero");
	ack_clear_a: assert property (ce_i && vector_ack_i[0] && !run0_q && !ctl_wr
		|=> !timer_overflow_flag_o[0]) else $error("vector acknowledge left flag set");
	stop_noflag_a: assert property (ce_i && !run0_q && !ctl_wr
		|=> !$rose(timer_overflow_flag_o[0])) else $error("stopped timer raised flag");
	clkout_en_a: assert property ($past(ce_i) |-> clock_out_en_o == $past(co_mode))
		else $error("clock-out enable disagrees with mode");
	off_still_a: assert property ((ce_i && !t3c_q[2])[*2] |=> $stable(clock_out_o))
		else $error("clock out moved while third timer off");
	rx_off_a: assert property ((ce_i && t3c_q[5] && !t3c_q[2])[*3] |-> !rx_baud_tick_o)
		else $error("receive tick from stopped third timer");
	tx_off_a: assert property ((ce_i && t3c_q[4] && !t3c_q[2])[*3] |-> !tx_baud_tick_o)
		else $error("transmit tick from stopped third timer");

	// main scenarios reached
	cover property (tx_baud_tick_o);
	cover property (rx_baud_tick_o);
	cover property ($rose(timer_overflow_flag_o[0]));
	cover property (clock_out_en_o);
endmodule : tmr_timer_unit_chk

bind tmr_timer_unit tmr_timer_unit_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
	.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i),
	.vector_ack_i(vector_ack_i), .sfr_rdata_o(sfr_rdata_o),
	.timer_overflow_flag_o(timer_overflow_flag_o), .rx_baud_tick_o(rx_baud_tick_o),
	.tx_baud_tick_o(tx_baud_tick_o), .clock_out_o(clock_out_o),
	.clock_out_en_o(clock_out_en_o));

// ### tb/tmr_cpu_model.sv
// cpu side model: register writes, reads and interrupt vector acknowledge
`timescale 1ns/1ps
module tmr_cpu_model
(
	input  wire logic       clk_i,
	input  wire logic [7:0] rdata_i,
	output logic      [7:0] addr_o,
	output logic            wr_o,
	output logic      [7:0] wdata_o,
	output logic      [1:0] ack_o
);
	// idle bus from time zero
	initial
	begin
		addr_o = 8'h00;
		wr_o = 1'b0;
		wdata_o = 8'h00;
		ack_o = 2'h0;
	end

	// one-cycle strobe; stale data is inverted so nothing leans on it
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wr_o <= 1'b1;
		wdata_o <= (a == 8'hC9) ? (d & 8'h03) : d;
		@(posedge clk_i);
		wr_o <= 1'b0;
		wdata_o <= ~d;
	endtask : wr

	// read data is registered, so it is taken one edge after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		@(posedge clk_i);
		#1 d = rdata_i;
	endtask : rd

	task automatic ack(input int n);
		@(posedge clk_i);
		ack_o[n] <= 1'b1;
		@(posedge clk_i);
		ack_o[n] <= 1'b0;
	endtask : ack
endmodule : tmr_cpu_model

// ### tb/tmr_timer_unit_test.sv
// self-checking bench for the timer unit with a cpu side model
`timescale 1ns/1ps
module tmr_timer_unit_test;
	logic       clk_i, nrst_i, ce, cp3, tg3, rxt, txt, co, coe, t3irq;
	logic [1:0] cpin, ipin, ack, flg;
	logic [7:0] addr, wdata, rdata, d;
	logic       wr;
	int         n_errors = 0, samples_checked = 0, seed = 32'h4a4f, i;
	int         shadow[int];
	int         regs[$] = '{8'h88, 8'h89, 8'hC8, 8'hC9, 8'h00};

	tmr_cpu_model u_tmr_cpu_model (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
		.wdata_o(wdata), .ack_o(ack));
	// short machine cycle keeps the run brief
	tmr_timer_unit #(.MCYC_CLKS(2), .THIRD_DIV(2)) u_tmr_timer_unit (.clk_i(clk_i),
		.nrst_i(nrst_i), .ce_i(ce), .sfr_addr_i(addr), .sfr_wr_i(wr), .sfr_wdata_i(wdata),
		.count_pin_i(cpin), .external_irq_pin_i(ipin), .vector_ack_i(ack),
		.third_count_pin_i(cp3), .third_trigger_pin_i(tg3), .sfr_rdata_o(rdata),
		.timer_overflow_flag_o(flg), .third_irq_o(t3irq), .rx_baud_tick_o(rxt),
		.tx_baud_tick_o(txt), .clock_out_o(co), .clock_out_en_o(coe));

	initial
	begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// writes also update the bench's register model
	task automatic w(input logic [7:0] a, input logic [7:0] v);
		u_tmr_cpu_model.wr(a, v);
		shadow[a] = (a == 8'hC9) ? (v & 8'h03) : v;
	endtask : w

	task automatic r(input logic [7:0] a, input logic [7:0] e);
		u_tmr_cpu_model.rd(a, d);
		chk(d, e);
	endtask : r

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop

	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_errors++;
		report_and_stop();
	end

	initial
	begin
		nrst_i = 1'b0;
		ce = 1'b1;
		cpin = 2'h3;
		ipin = 2'h3;
		cp3 = 1'b1;
		tg3 = 1'b1;
		repeat (6) @(posedge clk_i);
		nrst_i <= 1'b1;
		foreach (regs[j]) r(regs[j], 8'h00);
		// random register contents against the model
		for (i = 0; i < 4; i++)
		begin
			w(8'h89, 8'($random(seed)));
			r(8'h89, 8'(shadow[8'h89]));
			w(8'hC9, 8'($random(seed)));
			r(8'hC9, 8'(shadow[8'hC9]));
		end
		$display("register test done");
		// gate closed holds a preset count, opening it overflows 16 bits
		w(8'hC9, 8'h00);
		w(8'h89, 8'h09);
		ipin <= 2'h2;
		w(8'h8A, 8'hFF);
		w(8'h8C, 8'hFF);
		w(8'h88, 8'h10);
		repeat (20) @(posedge clk_i);
		r(8'h8A, 8'hFF);
		r(8'h8C, 8'hFF);
		ipin <= 2'h3;
		for (i = 0; i < 40 && flg[0] !== 1'b1; i++) @(negedge clk_i);
		chk(8'(flg[0]), 8'h01);
		r(8'h8C, 8'h00);
		// stop but keep the flag, so only the vector acknowledge can clear it
		w(8'h88, 8'h20);
		ce <= 1'b0;
		u_tmr_cpu_model.ack(0);
		@(negedge clk_i);
		chk(8'(flg[0]), 8'h01);
		@(posedge clk_i);
		ce <= 1'b1;
		u_tmr_cpu_model.ack(0);
		@(negedge clk_i);
		chk(8'(flg[0]), 8'h00);
		$display("gate test done");
		// prescaled mode: 13 ones wrap where 16 bits would not
		w(8'h89, 8'h00);
		w(8'h8A, 8'h1F);
		w(8'h8C, 8'hFF);
		w(8'h88, 8'h10);
		for (i = 0; i < 20 && flg[0] !== 1'b1; i++) @(negedge clk_i);
		chk(8'(flg[0]), 8'h01);
		w(8'h88, 8'h00);
		u_tmr_cpu_model.ack(0);
		// eight-bit reload keeps the high byte
		w(8'h89, 8'h02);
		w(8'h8C, 8'hA0);
		w(8'h8A, 8'hFE);
		w(8'h88, 8'h10);
		for (i = 0; i < 20 && flg[0] !== 1'b1; i++) @(negedge clk_i);
		chk(8'(flg[0]), 8'h01);
		w(8'h88, 8'h00);
		r(8'h8C, 8'hA0);
		u_tmr_cpu_model.rd(8'h8A, d);
		chk(d & 8'hF0, 8'hA0);
		u_tmr_cpu_model.ack(0);
		// counter mode counts a pin falling edge only
		w(8'h89, 8'h05);
		w(8'h8A, 8'hFF);
		w(8'h8C, 8'hFF);
		w(8'h88, 8'h10);
		repeat (10) @(posedge clk_i);
		chk(8'(flg[0]), 8'h00);
		cpin <= 2'h2;
		for (i = 0; i < 20 && flg[0] !== 1'b1; i++) @(negedge clk_i);
		chk(8'(flg[0]), 8'h01);
		w(8'h88, 8'h00);
		u_tmr_cpu_model.ack(0);
		$display("mode test done");
		// timer one in its mode 3 holds; split zero high byte takes its run and flag
		w(8'h89, 8'h30);
		w(8'h8B, 8'hFF);
		w(8'h8D, 8'hFF);
		w(8'h8C, 8'hFF);
		w(8'h88, 8'h40);
		repeat (30) @(posedge clk_i);
		chk(8'(flg[1]), 8'h00);
		r(8'h8B, 8'hFF);
		w(8'h89, 8'h33);
		for (i = 0; i < 20 && flg[1] !== 1'b1; i++) @(negedge clk_i);
		chk(8'(flg[1]), 8'h01);
		// timer one leaves its mode 3 and runs again as a baud source
		w(8'h89, 8'h23);
		for (i = 0; i < 20 && txt !== 1'b1; i++) @(negedge clk_i);
		chk(8'(txt), 8'h01);
		// serial selects on a stopped third timer mute timer one's ticks
		w(8'hC8, 8'h30);
		repeat (6) @(negedge clk_i);
		chk(8'(rxt), 8'h00);
		chk(8'(txt), 8'h00);
		w(8'h88, 8'h00);
		u_tmr_cpu_model.ack(1);
		$display("split test done");
		// third timer reload, baud and trigger
		w(8'h89, 8'h00);
		w(8'hCA, 8'h34);
		w(8'hCB, 8'h12);
		w(8'hCC, 8'hFF);
		w(8'hCD, 8'hFF);
		w(8'hC8, 8'h04);
		for (i = 0; i < 40 && t3irq !== 1'b1; i++) @(negedge clk_i);
		chk(8'(t3irq), 8'h01);
		r(8'hCD, 8'h12);
		u_tmr_cpu_model.rd(8'hC8, d);
		chk(d & 8'h80, 8'h80);
		// stop and preset, or baud mode would climb the whole word first
		w(8'hC8, 8'h00);
		w(8'hCC, 8'hFF);
		w(8'hCD, 8'hFF);
		w(8'hCA, 8'hF0);
		w(8'hCB, 8'hFF);
		w(8'hC8, 8'h14);
		for (i = 0; i < 60 && txt !== 1'b1; i++) @(negedge clk_i);
		chk(8'(txt), 8'h01);
		w(8'hC8, 8'h24);
		for (i = 0; i < 60 && rxt !== 1'b1; i++) @(negedge clk_i);
		chk(8'(rxt), 8'h01);
		chk(8'(t3irq), 8'h00);
		w(8'hC8, 8'h0C);
		tg3 <= 1'b0;
		repeat (8) @(posedge clk_i);
		u_tmr_cpu_model.rd(8'hC8, d);
		chk(d & 8'h40, 8'h40);
		w(8'hC8, 8'h00);
		w(8'hC9, 8'h02);
		w(8'hC8, 8'h04);
		repeat (3) @(posedge clk_i);
		#1 chk(8'(coe), 8'h01);
		for (i = 0; i < 60 && co !== 1'b1; i++) @(negedge clk_i);
		chk(8'(co), 8'h01);
		chk(8'(t3irq), 8'h00);
		// count pin mode steps only on a sampled falling edge
		w(8'hC8, 8'h00);
		w(8'hC9, 8'h00);
		w(8'hCC, 8'hFF);
		w(8'hCD, 8'hFF);
		w(8'hC8, 8'h06);
		repeat (10) @(posedge clk_i);
		chk(8'(t3irq), 8'h00);
		cp3 <= 1'b0;
		for (i = 0; i < 20 && t3irq !== 1'b1; i++) @(negedge clk_i);
		chk(8'(t3irq), 8'h01);
		w(8'hC8, 8'h00);
		$display("third timer test done");
		report_and_stop();
	end
endmodule : tmr_timer_unit_test
